/* File: rtl/secl_pkg.sv */
// Purpose: shared constants and types of the serial EEPROM configuration loader
// Assumes: 10 MHz core clock; one 7-bit EEPROM address on the master SMBus
// Notes: block layout (little endian): [addr lo][type:2, addr hi:6] then payload
package secl_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SMB_BIT_NS = 10000;
  // one SMBus bit is four quarter phases; longest time rounds down
  localparam int unsigned SMB_QTR_CYC = SMB_BIT_NS / (4 * CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // register map (byte offsets on the Avalon slave)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h4;
  localparam logic [3:0] OFF_SWITCH_CONTROL_REG = 4'h8;
  localparam int STS_DONE = 0;
  localparam int STS_UNMAPPED = 1;
  localparam int STS_ICS = 2;
  localparam int STS_NACK = 3;
  localparam int STS_ARB = 4;
  localparam int STS_MISC = 5;
  localparam int STS_BUSY = 6;
  localparam int CTL_IGN_CSUM = 0;
  localparam int SWC_HALT = 0;
  localparam logic RST_IGN_CSUM = 1'b0;
  localparam logic RST_HALT = 1'b0;

  // ----------------------------------------------------------------
  // block format and bus constants
  // ----------------------------------------------------------------
  localparam logic [1:0] BLK_SINGLE = 2'h0;
  localparam logic [1:0] BLK_SEQ = 2'h1;
  localparam logic [1:0] BLK_BAD = 2'h2;
  localparam logic [1:0] BLK_DONE = 2'h3;
  localparam int TYPE_LSB = 6;
  localparam int DW_ADDR_W = 14;
  localparam logic [7:0] CSUM_GOOD = 8'hff;
  localparam logic [15:0] EE_ADDR_LAST = 16'hffff;
  localparam logic [4:0] ARB_LIMIT = 5'h10;
  localparam logic [2:0] DEV_ADDR_HI = 3'h5;
  localparam logic SMB_RD = 1'b1;
  localparam logic SMB_WR = 1'b0;
  localparam logic [7:0] EE_MODE_MASK = 8'h0f;

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_TXBIT, S_TXACK, S_RXBIT, S_PARSE, S_WRCHK, S_RXACK, S_STOP, S_DONE
  } secl_state_t;

  typedef enum logic [2:0] {
    P_HDR0, P_HDR1, P_CNT0, P_CNT1, P_DATA
  } secl_parse_t;
endpackage : secl_pkg

/* File: rtl/secl_loader.sv */
// Purpose: reads configuration blocks from a serial EEPROM and writes register dwords
// Assumes: reg_hit_in decodes reg_addr_out combinationally in the same clock domain
// Notes: Avalon-MM slave holds status, control and switch control words
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns

module secl_loader #(
  parameter int QTR_CYC = secl_pkg::SMB_QTR_CYC,
  parameter logic [7:0] MODE_MASK = secl_pkg::EE_MODE_MASK
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic init_req_in,
  input wire logic [2:0] switch_operating_mode_in,
  input wire logic [3:0] eeprom_addr_straps_in,
  input wire logic smb_clk_in,
  output logic smb_clk_out,
  output logic smb_clk_oe_out,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_out,
  output logic reg_wr_out,
  output logic [15:0] reg_addr_out,
  output logic [31:0] reg_data_out,
  input wire logic reg_hit_in,
  output logic reset_halt_out,
  output logic eeprom_load_done_out,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  import secl_pkg::*;

  typedef struct packed {
    secl_state_t st;
    secl_parse_t ps;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic [2:0] bitn;
    logic [2:0] step;
    logic [7:0] shreg;
    logic ack_nack;
    logic sda_smp;
    logic [15:0] ee_addr;
    logic [7:0] sum;
    logic [4:0] arb_cnt;
    logic [DW_ADDR_W-1:0] dw_addr;
    logic [15:0] dw_cnt;
    logic [31:0] data;
    logic [1:0] bidx;
    logic scl_oe;
    logic sda_oe;
    logic wr;
    logic [15:0] wr_addr;
    logic done;
    logic unmapped;
    logic ics;
    logic nack;
    logic arb;
    logic misc;
    logic ign_csum;
    logic halt;
    logic av_wait;
    logic [31:0] av_rdata;
    logic [2:0] sda_sy;
    logic sda_f;
    logic [2:0] scl_sy;
    logic scl_f;
    logic [2:0] init_sy;
    logic init_f;
    logic init_prev;
    logic [2:0][2:0] mode_sy;
    logic [2:0] mode_f;
    logic [2:0][3:0] strap_sy;
    logic [3:0] strap_f;
  } secl_regs_t;

  secl_regs_t q;
  secl_regs_t d;
  logic [1:0] rst_pipe_q;
  logic rst_n;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic stall;
    logic req;
    logic e_ics;
    logic e_nack;
    logic e_arb;
    logic e_misc;
    logic fin;
    logic [7:0] b;
    logic [7:0] nsum;
    tick = 1'b0;
    stall = 1'b0;
    req = 1'b0;
    e_ics = 1'b0;
    e_nack = 1'b0;
    e_arb = 1'b0;
    e_misc = 1'b0;
    fin = 1'b0;
    b = q.shreg;
    nsum = q.sum + q.shreg;
    d = q;
    d.wr = 1'b0;

    // pins pass three flops; a change counts once stages two and three agree
    d.sda_sy = {q.sda_sy[1:0], smb_data_in};
    d.scl_sy = {q.scl_sy[1:0], smb_clk_in};
    d.init_sy = {q.init_sy[1:0], init_req_in};
    d.mode_sy = {q.mode_sy[1:0], switch_operating_mode_in};
    d.strap_sy = {q.strap_sy[1:0], eeprom_addr_straps_in};
    if (q.sda_sy[1] == q.sda_sy[2]) d.sda_f = q.sda_sy[2];
    if (q.scl_sy[1] == q.scl_sy[2]) d.scl_f = q.scl_sy[2];
    if (q.init_sy[1] == q.init_sy[2]) d.init_f = q.init_sy[2];
    if (q.mode_sy[1] == q.mode_sy[2]) d.mode_f = q.mode_sy[2];
    if (q.strap_sy[1] == q.strap_sy[2]) d.strap_f = q.strap_sy[2];
    d.init_prev = q.init_f;

    // Avalon slave: one wait cycle, answer with waitrequest low
    req = avs_read_in | avs_write_in;
    if (q.av_wait && req) begin
      d.av_wait = 1'b0;
      case (avs_address_in)
        OFF_STATUS: d.av_rdata = {25'h0, q.st != S_IDLE, q.misc, q.arb, q.nack, q.ics,
                                  q.unmapped, q.done};
        OFF_CONTROL: d.av_rdata = {31'h0, q.ign_csum};
        OFF_SWITCH_CONTROL_REG: d.av_rdata = {31'h0, q.halt};
        default: d.av_rdata = 32'h0;
      endcase
    end else begin
      d.av_wait = 1'b1;
    end
    // status bits 0 to 5 are write-one-to-clear, busy is read-only; hardware sets below win
    if (req && !q.av_wait && avs_write_in) begin
      case (avs_address_in)
        OFF_STATUS: begin
          if (avs_writedata_in[STS_DONE]) d.done = 1'b0;
          if (avs_writedata_in[STS_UNMAPPED]) d.unmapped = 1'b0;
          if (avs_writedata_in[STS_ICS]) d.ics = 1'b0;
          if (avs_writedata_in[STS_NACK]) d.nack = 1'b0;
          if (avs_writedata_in[STS_ARB]) d.arb = 1'b0;
          if (avs_writedata_in[STS_MISC]) d.misc = 1'b0;
        end
        OFF_CONTROL: d.ign_csum = avs_writedata_in[CTL_IGN_CSUM];
        OFF_SWITCH_CONTROL_REG: d.halt = avs_writedata_in[SWC_HALT];
        default: ;
      endcase
    end

    // quarter-bit timebase; a slave holding the clock low stretches phase two
    tick = (q.qcnt == 8'h0);
    d.qcnt = tick ? 8'(QTR_CYC - 1) : q.qcnt - 8'h1;
    stall = (q.ph == 2'h2) && !q.scl_oe && !q.scl_f;
    if (tick && !stall && q.st != S_IDLE && q.st != S_PARSE && q.st != S_WRCHK)
      d.ph = q.ph + 2'h1;
    if (stall) d.ph = q.ph;

    case (q.st)
      S_IDLE: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (q.init_f && !q.init_prev && MODE_MASK[q.mode_f]) begin
          d.st = S_START;
          d.ph = 2'h0;
          d.step = 3'h0;
          d.ee_addr = 16'h0;
          d.sum = 8'h0;
          d.arb_cnt = 5'h0;
          d.ps = P_HDR0;
        end
      end
      S_START: if (tick) begin
        case (q.ph)
          2'h0: d.sda_oe = 1'b0;
          2'h1: d.scl_oe = 1'b0;
          2'h2: if (!stall) d.sda_oe = 1'b1;
          default: begin
            d.scl_oe = 1'b1;
            d.st = S_TXBIT;
            d.bitn = 3'h7;
            d.shreg = {DEV_ADDR_HI, q.strap_f, (q.step == 3'h3) ? SMB_RD : SMB_WR};
          end
        endcase
      end
      S_TXBIT: if (tick && !stall) begin
        case (q.ph)
          2'h0: d.sda_oe = ~q.shreg[7];
          2'h1: d.scl_oe = 1'b0;
          2'h2: begin
            d.sda_smp = q.sda_f;
            if (q.shreg[7] && !q.sda_f) begin
              // lost to another master: retry the whole access at once, until the sixteenth loss in a row (ARB_LIMIT) aborts
              d.sda_oe = 1'b0;
              d.arb_cnt = q.arb_cnt + 5'h1;
              d.ph = 2'h0;
              d.step = 3'h0;
              d.st = S_START;
              if (q.arb_cnt + 5'h1 == ARB_LIMIT) e_arb = 1'b1;
            end
          end
          default: begin
            d.scl_oe = 1'b1;
            d.shreg = {q.shreg[6:0], 1'b0};
            if (q.sda_f != q.sda_smp) e_misc = 1'b1;
            else if (q.bitn == 3'h0) d.st = S_TXACK;
            d.bitn = q.bitn - 3'h1;
          end
        endcase
      end
      S_TXACK: if (tick && !stall) begin
        case (q.ph)
          2'h0: d.sda_oe = 1'b0;
          2'h1: d.scl_oe = 1'b0;
          2'h2: begin
            d.sda_smp = q.sda_f;
            if (q.sda_f) e_nack = 1'b1;
          end
          default: begin
            d.scl_oe = 1'b1;
            d.arb_cnt = 5'h0;
            d.step = q.step + 3'h1;
            d.bitn = 3'h7;
            if (q.sda_f != q.sda_smp) e_misc = 1'b1;
            else begin
              case (q.step)
                3'h0: begin
                  d.shreg = q.ee_addr[15:8];
                  d.st = S_TXBIT;
                end
                3'h1: begin
                  d.shreg = q.ee_addr[7:0];
                  d.st = S_TXBIT;
                end
                3'h2: d.st = S_START;
                default: d.st = S_RXBIT;
              endcase
            end
          end
        endcase
      end
      S_RXBIT: if (tick && !stall) begin
        case (q.ph)
          2'h0: d.sda_oe = 1'b0;
          2'h1: d.scl_oe = 1'b0;
          2'h2: begin
            d.sda_smp = q.sda_f;
            d.shreg = {q.shreg[6:0], q.sda_f};
          end
          default: begin
            d.scl_oe = 1'b1;
            if (q.sda_f != q.sda_smp) e_misc = 1'b1;
            else if (q.bitn == 3'h0) d.st = S_PARSE;
            d.bitn = q.bitn - 3'h1;
          end
        endcase
      end
      S_PARSE: begin
        d.sum = nsum;
        d.ee_addr = q.ee_addr + 16'h1;
        d.st = S_RXACK;
        d.ph = 2'h0;
        case (q.ps)
          P_HDR0: begin
            d.dw_addr[7:0] = b;
            d.ps = P_HDR1;
          end
          P_HDR1: begin
            d.dw_addr[DW_ADDR_W-1:8] = b[DW_ADDR_W-9:0];
            d.bidx = 2'h0;
            case (b[TYPE_LSB +: 2])
              BLK_SINGLE: begin
                d.dw_cnt = 16'h1;
                d.ps = P_DATA;
              end
              BLK_SEQ: d.ps = P_CNT0;
              BLK_DONE: begin
                fin = 1'b1;
                if (!q.ign_csum && nsum != CSUM_GOOD) e_ics = 1'b1;
              end
              default: e_ics = 1'b1;
            endcase
          end
          P_CNT0: begin
            d.dw_cnt[7:0] = b;
            d.ps = P_CNT1;
          end
          P_CNT1: begin
            d.dw_cnt[15:8] = b;
            d.ps = ({b, q.dw_cnt[7:0]} == 16'h0) ? P_HDR0 : P_DATA;
          end
          default: begin
            d.data[q.bidx * 8 +: 8] = b;
            d.bidx = q.bidx + 2'h1;
            if (q.bidx == 2'h3) begin
              d.st = S_WRCHK;
              d.wr_addr = {q.dw_addr, 2'b00};
            end
          end
        endcase
        if (!fin && q.ee_addr == EE_ADDR_LAST) e_ics = 1'b1;
        d.ack_nack = fin | e_ics;
        if (e_ics) d.st = S_RXACK;
      end
      S_WRCHK: begin
        if (reg_hit_in) d.wr = 1'b1;
        else d.unmapped = 1'b1;
        d.dw_addr = q.dw_addr + DW_ADDR_W'(1);
        d.dw_cnt = q.dw_cnt - 16'h1;
        if (q.dw_cnt == 16'h1) d.ps = P_HDR0;
        d.st = S_RXACK;
      end
      S_RXACK: if (tick && !stall) begin
        case (q.ph)
          2'h0: d.sda_oe = ~q.ack_nack;
          2'h1: d.scl_oe = 1'b0;
          2'h2: ;
          default: begin
            d.scl_oe = 1'b1;
            d.bitn = 3'h7;
            d.st = q.ack_nack ? S_STOP : S_RXBIT;
          end
        endcase
      end
      S_STOP: if (tick && !stall) begin
        case (q.ph)
          2'h0: d.sda_oe = 1'b1;
          2'h1: d.scl_oe = 1'b0;
          2'h2: d.sda_oe = 1'b0;
          default: d.st = S_DONE;
        endcase
      end
      S_DONE: begin
        d.done = 1'b1;
        d.st = S_IDLE;
      end
      default: d.st = S_IDLE;
    endcase

    // aborts: bus errors end with a STOP, arbitration loss just lets go
    if (e_ics) d.ics = 1'b1;
    if (e_nack) d.nack = 1'b1;
    if (e_misc) d.misc = 1'b1;
    if (e_arb) d.arb = 1'b1;
    if (e_ics | e_nack | e_misc | e_arb) d.halt = 1'b1;
    if (e_nack | e_misc) begin
      d.scl_oe = 1'b1;
      d.ph = 2'h0;
      d.st = S_STOP;
    end
    if (e_arb) begin
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.st = S_DONE;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= S_IDLE;
      q.ps <= P_HDR0;
      q.ign_csum <= RST_IGN_CSUM;
      q.halt <= RST_HALT;
      q.av_wait <= 1'b1;
      q.sda_sy <= 3'h7;
      q.sda_f <= 1'b1;
      q.scl_sy <= 3'h7;
      q.scl_f <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign smb_clk_out = 1'b0;
  assign smb_data_out = 1'b0;
  assign smb_clk_oe_out = q.scl_oe;
  assign smb_data_oe_out = q.sda_oe;
  assign reg_wr_out = q.wr;
  assign reg_addr_out = q.wr_addr;
  assign reg_data_out = q.data;
  assign reset_halt_out = q.halt;
  assign eeprom_load_done_out = q.done;
  assign avs_readdata_out = q.av_rdata;
  assign avs_waitrequest_out = q.av_wait;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  sequence s_done_blk;
    q.st == S_PARSE && q.ps == P_HDR1 && q.shreg[TYPE_LSB +: 2] == BLK_DONE;
  endsequence
  sequence s_any_err;
    $rose(q.ics) || $rose(q.nack) || $rose(q.arb) || $rose(q.misc);
  endsequence

  property p_start_clear;
    q.st == S_IDLE ##1 q.st == S_START |-> q.ee_addr == 16'h0 && q.sum == 8'h0;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("load not started at zero");
  property p_wr_aligned;
    reg_wr_out |-> reg_addr_out[1:0] == 2'b00 && $past(q.st) == S_WRCHK;
  endproperty
  a_wr_aligned: assert property (p_wr_aligned) else $error("register write misaligned");
  property p_unmapped;
    q.st == S_WRCHK && !reg_hit_in |=> q.unmapped && !reg_wr_out;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write not dropped");
  property p_csum_bad;
    s_done_blk ##0 (!q.ign_csum && q.sum + q.shreg != CSUM_GOOD) |=> q.ics && q.halt;
  endproperty
  a_csum_bad: assert property (p_csum_bad) else $error("checksum mismatch missed");
  property p_csum_ign;
    s_done_blk ##0 (q.ign_csum && q.ee_addr != EE_ADDR_LAST) |=> $stable(q.ics);
  endproperty
  a_csum_ign: assert property (p_csum_ign) else $error("checksum checked while ignored");
  property p_bad_type;
    q.st == S_PARSE && q.ps == P_HDR1 && q.shreg[TYPE_LSB +: 2] == BLK_BAD |=> q.ics;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("type 0x2 not rejected");
  property p_wrap;
    q.st == S_PARSE && q.ee_addr == EE_ADDR_LAST && q.ps != P_HDR1 |=> q.ics && q.ack_nack;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address rollover missed");
  property p_nack;
    q.st == S_TXACK && q.qcnt == 8'h0 && q.ph == 2'h2 && q.sda_f && q.scl_f
      |=> q.nack && q.st == S_STOP;
  endproperty
  a_nack: assert property (p_nack) else $error("nack not reported");
  property p_halt;
    s_any_err |-> q.halt;
  endproperty
  a_halt: assert property (p_halt) else $error("error without reset halt");
  property p_done_end;
    s_any_err |-> ##[1:1000] q.done;
  endproperty
  a_done_end: assert property (p_done_end) else $error("done not set after abort");
  property p_misc;
    $rose(q.misc) |-> q.st == S_STOP && q.scl_oe && q.halt;
  endproperty
  a_misc: assert property (p_misc) else $error("misplaced bus condition not aborted");
endmodule : secl_loader

/* File: testbench/secl_ee_model.sv */
// Purpose: behavioural serial EEPROM slave on the master SMBus
// Assumes: the bench resolves both open-drain wires with pull-ups
// Notes: jam_in acts as a rival master, slow_in stretches every SCL low phase,
//        glitch_in pulls SDA low in the middle of a high SCL phase of a read bit
`timescale 1ns/1ns
module secl_ee_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [3:0] straps_in,
  input wire logic nack_in,
  input wire logic jam_in,
  input wire logic slow_in,
  input wire logic glitch_in,
  output logic sda_oe_out,
  output logic scl_oe_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] sh, cur;
  logic [15:0] ptr;
  logic dr, jm, ak_ph, gd;
  int bc, st;
  assign sda_oe_out = dr | jm | gd;
  initial begin
    dr = 0;
    jm = 0;
    gd = 0;
    scl_oe_out = 0;
    st = 4;
    bc = 0;
    ak_ph = 0;
    ptr = 0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  end
  // ----------------------------------------------------------------
  // framing; st: 0 device byte, 1/2 pointer bytes, 3 reading, 4 idle
  // ----------------------------------------------------------------
  always @(negedge sda_in) if (scl_in) begin
    st = 0;
    bc = 0;
    ak_ph = 0;
    dr = 0;
  end
  always @(posedge sda_in) if (scl_in) st = 4;
  always @(posedge scl_in) if (st != 4) begin
    if (!ak_ph) begin
      sh = {sh[6:0], sda_in};
      bc++;
    end else if (st == 3 && sda_in) st = 4;
  end
  // pointer wraps at 16 bits like a real part
  always @(negedge scl_in) if (st != 4) begin
    if (ak_ph) begin
      ak_ph = 0;
      dr = 0;
      if (st == 3) begin
        cur = mem[ptr];
        ptr++;
        dr = ~cur[7];
      end
    end else if (bc == 8) begin
      ak_ph = 1;
      bc = 0;
      dr = 0;
      if (st != 3) begin
        dr = ~nack_in;
        if (st == 0) begin
          dr = dr & (sh[7:1] == {3'h5, straps_in});
          st = sh[0] ? 3 : 1;
        end else if (st == 1) begin
          ptr[15:8] = sh;
          st = 2;
        end else ptr[7:0] = sh;
      end
    end else if (st == 3) dr = ~cur[7 - bc];
  end
  always @(negedge scl_in) if (slow_in) begin
    scl_oe_out = 1;
    #1000 scl_oe_out = 0;
  end
  // holds SDA low for 700 ns after each SCL fall, into the next high phase; released while SCL is still high
  always @(negedge scl_in) if (jam_in) begin
    jm = 1;
    #700 jm = 0;
  end
  // only a one bit shows the pulse, so the loader sees SDA move while SCL is high
  always @(posedge scl_in) if (glitch_in && st == 3 && !ak_ph) begin
    #250 gd = 1;
    #500 gd = 0;
  end
endmodule : secl_ee_model

/* File: testbench/serial_eeprom_config_loader_tb_top.sv */
// Purpose: self-checking bench of the configuration loader
// Assumes: QTR_CYC 2, so one SMBus bit takes twelve core cycles, as SCL synchronising stretches phase two by two ticks
// Notes: the top quarter of the register space decodes as unmapped
`timescale 1ns/1ns
module serial_eeprom_config_loader_tb_top;
  import secl_pkg::*;
  logic clk, rst_b, init, rd, wr, wreq, nack, jam, slow, wr_p, halt, done, bad;
  logic scl_oe, sda_oe, m_scl, m_sda, glitch;
  logic [2:0] mode;
  logic [3:0] strap, aa;
  logic [31:0] wd, rdd, lf, q, rdat;
  logic [15:0] ra;
  logic [7:0] img[$];
  logic [15:0] ea[$], ga[$];
  logic [31:0] ed[$], gd[$];
  int num_errors, cmp_count;
  wire logic scl_w = !(scl_oe | m_scl);
  wire logic sda_w = !(sda_oe | m_sda);
  wire logic hit = ra[15:14] != 2'b11;
  secl_loader #(.QTR_CYC(2)) DUT (
    .clock_in(clk), .rst_b_in(rst_b), .init_req_in(init), .switch_operating_mode_in(mode),
    .eeprom_addr_straps_in(strap), .smb_clk_in(scl_w), .smb_clk_out(),
    .smb_clk_oe_out(scl_oe), .smb_data_in(sda_w), .smb_data_out(), .smb_data_oe_out(sda_oe),
    .reg_wr_out(wr_p), .reg_addr_out(ra), .reg_data_out(rdat), .reg_hit_in(hit),
    .reset_halt_out(halt), .eeprom_load_done_out(done), .avs_address_in(aa),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdd),
    .avs_waitrequest_out(wreq));
  secl_ee_model M (.scl_in(scl_w), .sda_in(sda_w), .straps_in(strap), .nack_in(nack),
    .jam_in(jam), .slow_in(slow), .glitch_in(glitch), .sda_oe_out(m_sda),
    .scl_oe_out(m_scl));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (wr_p === 1'b1) begin
    ga.push_back(ra);
    gd.push_back(rdat);
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // avalon master: hold the request until waitrequest is sampled low
  // ----------------------------------------------------------------
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    aa <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    r = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avs
  // block bytes and the writes they should cause; nothing after a bad type is expected
  task automatic blk(input logic [13:0] a, input logic [1:0] t, input int n, input bit sq);
    logic [15:0] ba;
    if (t == BLK_BAD) bad = 1;
    img.push_back(a[7:0]);
    img.push_back({t, a[13:8]});
    if (sq) begin
      img.push_back(n[7:0]);
      img.push_back(n[15:8]);
    end
    for (int i = 0; i < n; i++) begin
      lf = nx(lf);
      for (int b = 0; b < 4; b++) img.push_back(lf[8*b +: 8]);
      ba = {a + 14'(i), 2'b00};
      if (ba[15:14] != 2'b11 && !bad) begin
        ea.push_back(ba);
        ed.push_back(lf);
      end
    end
  endtask : blk
  task automatic run(input int kind, input logic [2:0] md, input logic ign, input logic nk,
                     input logic jm, input logic sl, input logic [6:0] es, input logic eh);
    logic [7:0] s;
    int n;
    img.delete();
    ea.delete();
    ed.delete();
    ga.delete();
    gd.delete();
    bad = 0;
    lf = nx(lf);
    blk({1'b0, lf[20:8]}, BLK_SINGLE, 1, 1'b0);
    if (kind == 2) blk(14'h0010, BLK_BAD, 1, 1'b0);
    blk({1'b0, lf[12:0]}, BLK_SEQ, 3, 1'b1);
    blk({2'b11, lf[11:0]}, BLK_SINGLE, 1, 1'b0);
    blk(lf[13:0], BLK_SEQ, 0, 1'b1);
    s = {BLK_DONE, 6'h0};
    foreach (img[i]) s += img[i];
    img.push_back(kind == 1 ? ~s ^ 8'h01 : ~s);
    img.push_back({BLK_DONE, 6'h0});
    if (nk | jm | (kind == 3) | md[2]) begin
      ea.delete();
      ed.delete();
    end
    foreach (img[i]) M.mem[i] = img[i];
    @(posedge clk);
    rst_b <= 1'b0;
    init <= 1'b0;
    mode <= md;
    strap <= lf[3:0];
    nack <= nk;
    jam <= jm;
    slow <= sl;
    glitch <= (kind == 3);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    avs(1'b1, OFF_CONTROL, {31'h0, ign}, q);
    repeat (4) @(posedge clk);
    init <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    avs(1'b0, OFF_STATUS, 32'h0, q);
    chk("status", {25'h0, es}, q);
    avs(1'b0, OFF_SWITCH_CONTROL_REG, 32'h0, q);
    chk("switch_control_reg", {31'h0, eh}, q);
    chk("halt_pin", {31'h0, eh}, {31'h0, halt});
    chk("done_pin", {31'h0, es[0]}, {31'h0, done});
    chk("wr_count", ea.size(), ga.size());
    foreach (ea[i]) if (i < ga.size()) begin
      chk("wr_addr", {16'h0, ea[i]}, {16'h0, ga[i]});
      chk("wr_data", ed[i], gd[i]);
    end
  endtask : run
  initial begin
    rst_b = 0;
    init = 0;
    mode = 0;
    strap = 0;
    rd = 0;
    wr = 0;
    aa = 0;
    wd = 0;
    nack = 0;
    jam = 0;
    slow = 0;
    glitch = 0;
    lf = 32'hf765;
    num_errors = 0;
    cmp_count = 0;
    run(0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h03, 1'b0);
    avs(1'b1, OFF_STATUS, 32'h3f, q);
    avs(1'b0, OFF_STATUS, 32'h0, q);
    chk("status_w1c", 32'h0, q);
    avs(1'b0, 4'hc, 32'h0, q);
    chk("unmapped_rd", 32'h0, q);
    run(1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 7'h07, 1'b1);
    run(1, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 7'h03, 1'b0);
    run(2, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 7'h05, 1'b1);
    run(0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 7'h09, 1'b1);
    run(0, 3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 7'h11, 1'b1);
    run(0, 3'h5, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00, 1'b0);
    run(3, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h21, 1'b1);
    wrap_up();
  end
  initial begin
    #8000000;
    num_errors++;
    wrap_up();
  end
endmodule : serial_eeprom_config_loader_tb_top
